// ==== logic/status_map.vh ====
// Register map, field widths and reset values of the status reporting block.
// Included by every design file of the block; definitions only.
`ifndef STATUS_MAP_VH
`define STATUS_MAP_VH

`define STAT_W 15
`define STAT_ONES 15'h7fff
`define STAT_ZERO 15'h0000
`define ERR_W 16
`define ERR_NONE 16'h0000
`define ERR_DEPTH 8
`define ERR_PTR_W 3
`define ERR_CNT_W 4

`define ADDR_W 8
`define A_OPER_COND 8'h00
`define A_OPER_EVENT 8'h04
`define A_OPER_ENABLE 8'h08
`define A_OPER_PTRANS 8'h0c
`define A_OPER_NTRANS 8'h10
`define A_QUES_COND 8'h14
`define A_QUES_EVENT 8'h18
`define A_QUES_ENABLE 8'h1c
`define A_QUES_PTRANS 8'h20
`define A_QUES_NTRANS 8'h24
`define A_PRESET 8'h28
`define A_ERR_NEXT 8'h2c
`define A_ERR_COUNT 8'h30
`define A_IRQ_STATUS 8'h34
`define A_IRQ_MASK 8'h38

`define IRQ_W 3
`define IRQ_OPER 0
`define IRQ_QUES 1
`define IRQ_ERR 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== logic/status_group.v ====
// One status register group: condition, transition masks, event word, enable.
// Assumes the parent decodes bus accesses into one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
`include "status_map.vh"

module status_group (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Live condition from the hardware
    input wire [`STAT_W-1:0] cond_in,
    // Strobes from the register decoder
    input wire preset,
    input wire wr_enable,
    input wire wr_ptrans,
    input wire wr_ntrans,
    input wire rd_event,
    input wire [`STAT_W-1:0] wdata,
    // Register contents
    output reg [`STAT_W-1:0] cond,
    output reg [`STAT_W-1:0] event_word,
    output reg [`STAT_W-1:0] enable,
    output reg [`STAT_W-1:0] ptrans,
    output reg [`STAT_W-1:0] ntrans,
    output reg summary,
    output reg event_pulse
);

    wire [`STAT_W-1:0] rise;
    wire [`STAT_W-1:0] fall;
    wire [`STAT_W-1:0] hits;

    assign rise = cond_in & ~cond & ptrans;
    assign fall = ~cond_in & cond & ntrans;
    assign hits = rise | fall;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cond <= `STAT_ZERO;
            event_word <= `STAT_ZERO;
            summary <= 1'b0;
            event_pulse <= 1'b0;
        end else begin
            cond <= cond_in;
            // A new hit in the read cycle survives the clear.
            if (rd_event) begin
                event_word <= hits;
            end else begin
                event_word <= event_word | hits;
            end
            summary <= |(event_word & enable);
            event_pulse <= |hits;
        end
    end

    // Masks reset only by the power-on reset or the preset strobe.
    always @(posedge aclk) begin
        if (!aresetn || preset) begin
            ptrans <= `STAT_ONES;
            ntrans <= `STAT_ZERO;
            enable <= `STAT_ZERO;
        end else begin
            if (wr_enable) begin
                enable <= wdata;
            end
            if (wr_ptrans) begin
                ptrans <= wdata;
            end
            if (wr_ntrans) begin
                ntrans <= wdata;
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/error_queue.v ====
// First-in first-out error queue; a pop returns the oldest code or zero.
// Assumes push and pop are one-cycle strobes; a push into a full queue is lost unless a pop comes in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "status_map.vh"

module error_queue (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Producer side
    input wire push,
    input wire [`ERR_W-1:0] push_code,
    // Consumer side
    input wire pop,
    output wire [`ERR_W-1:0] head,
    output reg [`ERR_CNT_W-1:0] count,
    output wire full
);

    reg [`ERR_W-1:0] mem [0:`ERR_DEPTH-1];
    reg [`ERR_PTR_W-1:0] wr_ptr;
    reg [`ERR_PTR_W-1:0] rd_ptr;
    wire empty;
    wire do_push;
    wire do_pop;

    assign empty = (count == {`ERR_CNT_W{1'b0}});
    assign full = count[`ERR_CNT_W-1];
    assign head = empty ? `ERR_NONE : mem[rd_ptr];
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);

    always @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_code;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= {`ERR_PTR_W{1'b0}};
            rd_ptr <= {`ERR_PTR_W{1'b0}};
            count <= {`ERR_CNT_W{1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/status_report.v ====
// Status reporting block: operation and questionable groups, error queue,
// interrupt status and an AXI4-Lite register slave.
// Assumes conditions and error pushes are synchronous to aclk.
// The general reset input is unread on purpose.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "status_map.vh"

module status_report (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address channel
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // Write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address channel
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // Read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Hardware status inputs
    input wire [`STAT_W-1:0] oper_cond_in,
    input wire [`STAT_W-1:0] ques_cond_in,
    input wire err_push,
    input wire [`ERR_W-1:0] err_code,
    // General instrument reset; status state ignores it.
    input wire inst_reset,
    // Outputs to the next status level
    output reg oper_summary,
    output reg ques_summary,
    output reg irq
);

    // Write bookkeeping: address and data may arrive in either order.
    reg aw_held;
    reg w_held;
    reg [`ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    reg [`IRQ_W-1:0] irq_status;
    reg [`IRQ_W-1:0] irq_mask;

    wire wr_go;
    wire rd_go;
    wire [`STAT_W-1:0] wr_val;
    wire full_word;

    // One-cycle strobes decoded from the bus.
    wire wr_oper_enable;
    wire wr_oper_ptrans;
    wire wr_oper_ntrans;
    wire wr_ques_enable;
    wire wr_ques_ptrans;
    wire wr_ques_ntrans;
    wire wr_irq_status;
    wire wr_irq_mask;
    wire rd_oper_event;
    wire rd_ques_event;
    wire err_pop;

    wire [`STAT_W-1:0] oper_cond;
    wire [`STAT_W-1:0] oper_event;
    wire [`STAT_W-1:0] oper_enable;
    wire [`STAT_W-1:0] oper_ptrans;
    wire [`STAT_W-1:0] oper_ntrans;
    wire [`STAT_W-1:0] ques_cond;
    wire [`STAT_W-1:0] ques_event;
    wire [`STAT_W-1:0] ques_enable;
    wire [`STAT_W-1:0] ques_ptrans;
    wire [`STAT_W-1:0] ques_ntrans;
    wire oper_sum;
    wire ques_sum;
    wire oper_hit;
    wire ques_hit;
    wire [`ERR_W-1:0] err_head;
    wire [`ERR_CNT_W-1:0] err_count;
    wire err_full;
    wire do_preset;
    wire [`IRQ_W-1:0] irq_events;

    reg [31:0] next_rdata;
    reg next_rresp_err;

    // Decode shared by the write strobes.
    function is_wr;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] target;
        begin
            is_wr = (a == target);
        end
    endfunction

    function [31:0] widen;
        input [`STAT_W-1:0] v;
        begin
            widen = {{(32-`STAT_W){1'b0}}, v};
        end
    endfunction

    // A write waits until the previous response is taken.
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    // Upper bits are dropped so stored values never pass 32767.
    assign wr_val = w_data[`STAT_W-1:0];
    assign full_word = (w_strb[1:0] == 2'h3);
    assign do_preset = wr_go && full_word && is_wr(aw_addr, `A_PRESET);

    assign wr_oper_enable = wr_go && full_word && is_wr(aw_addr, `A_OPER_ENABLE);
    assign wr_oper_ptrans = wr_go && full_word && is_wr(aw_addr, `A_OPER_PTRANS);
    assign wr_oper_ntrans = wr_go && full_word && is_wr(aw_addr, `A_OPER_NTRANS);
    assign wr_ques_enable = wr_go && full_word && is_wr(aw_addr, `A_QUES_ENABLE);
    assign wr_ques_ptrans = wr_go && full_word && is_wr(aw_addr, `A_QUES_PTRANS);
    assign wr_ques_ntrans = wr_go && full_word && is_wr(aw_addr, `A_QUES_NTRANS);

    // Interrupt registers fit in the lowest byte lane.
    assign wr_irq_status = wr_go && w_strb[0] && is_wr(aw_addr, `A_IRQ_STATUS);
    assign wr_irq_mask = wr_go && w_strb[0] && is_wr(aw_addr, `A_IRQ_MASK);

    // Reads with side effects act on the edge that takes the address.
    assign rd_oper_event = rd_go && (s_axi_araddr == `A_OPER_EVENT);
    assign rd_ques_event = rd_go && (s_axi_araddr == `A_QUES_EVENT);
    assign err_pop = rd_go && (s_axi_araddr == `A_ERR_NEXT);

    // The instrument reset is deliberately not wired to the groups.
    status_group u_oper (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond_in(oper_cond_in),
        .preset(do_preset),
        .wr_enable(wr_oper_enable),
        .wr_ptrans(wr_oper_ptrans),
        .wr_ntrans(wr_oper_ntrans),
        .rd_event(rd_oper_event),
        .wdata(wr_val),
        .cond(oper_cond),
        .event_word(oper_event),
        .enable(oper_enable),
        .ptrans(oper_ptrans),
        .ntrans(oper_ntrans),
        .summary(oper_sum),
        .event_pulse(oper_hit)
    );

    status_group u_ques (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond_in(ques_cond_in),
        .preset(do_preset),
        .wr_enable(wr_ques_enable),
        .wr_ptrans(wr_ques_ptrans),
        .wr_ntrans(wr_ques_ntrans),
        .rd_event(rd_ques_event),
        .wdata(wr_val),
        .cond(ques_cond),
        .event_word(ques_event),
        .enable(ques_enable),
        .ptrans(ques_ptrans),
        .ntrans(ques_ntrans),
        .summary(ques_sum),
        .event_pulse(ques_hit)
    );

    // Codes are stored as two's complement, so sign tells the origin.
    error_queue u_errq (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(err_push),
        .push_code(err_code),
        .pop(err_pop),
        .head(err_head),
        .count(err_count),
        .full(err_full)
    );

    assign irq_events[`IRQ_OPER] = oper_hit;
    assign irq_events[`IRQ_QUES] = ques_hit;
    assign irq_events[`IRQ_ERR] = err_push;

    // Write channel handshakes.
    // While idle, ready is offered every other cycle.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {`ADDR_W{1'b0}};
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;

            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end

            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `A_OPER_ENABLE,
                    `A_OPER_PTRANS,
                    `A_OPER_NTRANS,
                    `A_QUES_ENABLE,
                    `A_QUES_PTRANS,
                    `A_QUES_NTRANS,
                    `A_PRESET,
                    `A_IRQ_STATUS,
                    `A_IRQ_MASK: begin
                        s_axi_bresp <= `RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read mux; reading the condition words has no side effect.
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp_err = 1'b0;
        case (s_axi_araddr)
            `A_OPER_COND: next_rdata = widen(oper_cond);
            `A_OPER_EVENT: next_rdata = widen(oper_event);
            `A_OPER_ENABLE: next_rdata = widen(oper_enable);
            `A_OPER_PTRANS: next_rdata = widen(oper_ptrans);
            `A_OPER_NTRANS: next_rdata = widen(oper_ntrans);
            `A_QUES_COND: next_rdata = widen(ques_cond);
            `A_QUES_EVENT: next_rdata = widen(ques_event);
            `A_QUES_ENABLE: next_rdata = widen(ques_enable);
            `A_QUES_PTRANS: next_rdata = widen(ques_ptrans);
            `A_QUES_NTRANS: next_rdata = widen(ques_ntrans);
            `A_PRESET: next_rdata = 32'h00000000;
            // Sign-extended so software sees negative standard codes.
            `A_ERR_NEXT: next_rdata = {{(32-`ERR_W){err_head[`ERR_W-1]}}, err_head};
            // Full flag sits just above the four count bits.
            `A_ERR_COUNT: next_rdata = {{(31-`ERR_CNT_W){1'b0}}, err_full, err_count};
            `A_IRQ_STATUS: next_rdata = {{(32-`IRQ_W){1'b0}}, irq_status};
            `A_IRQ_MASK: next_rdata = {{(32-`IRQ_W){1'b0}}, irq_mask};
            default: next_rresp_err = 1'b1;
        endcase
    end

    // Read channel: one read under way at a time.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp_err ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Interrupt status: sticky, write one to clear; a new event wins.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= {`IRQ_W{1'b0}};
            irq_mask <= {`IRQ_W{1'b0}};
            oper_summary <= 1'b0;
            ques_summary <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (wr_irq_status) begin
                irq_status <= (irq_status & ~w_data[`IRQ_W-1:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
            if (wr_irq_mask) begin
                irq_mask <= w_data[`IRQ_W-1:0];
            end
            oper_summary <= oper_sum;
            ques_summary <= ques_sum;
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule
`default_nettype wire

// ==== bench/status_report_checker.sv ====
// Concurrent checks on the bus and summary ports of the status block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "status_map.vh"
module status_report_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status
    input wire logic [14:0] oper_cond_in,
    input wire logic [14:0] ques_cond_in,
    input wire logic oper_summary,
    input wire logic ques_summary
);
    // The error queue word is signed; every other word is zero above the field.
    logic [7:0] rd_addr;

    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    rvalid_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped or changed");
    upper_zero_a: assert property (s_axi_rvalid |-> ((rd_addr == `A_ERR_NEXT) ?
        (s_axi_rdata[31:16] == {16{s_axi_rdata[15]}}) : (s_axi_rdata[31:15] == 17'h00000)))
        else $error("read data above the field");
    // A summary can only fall after an event read, a mask write or a preset write, all of which use the bus.
    oper_keep_a: assert property (
        (!s_axi_arvalid && !s_axi_awvalid)[*6] ##0 oper_summary |=> oper_summary)
        else $error("summary fell without a bus access");
    oper_cause_a: assert property (
        ($stable(oper_cond_in) && !s_axi_awvalid)[*6] |=> !$rose(oper_summary))
        else $error("operation summary rose without cause");
    ques_cause_a: assert property (
        ($stable(ques_cond_in) && !s_axi_awvalid)[*6] |=> !$rose(ques_summary))
        else $error("questionable summary rose without cause");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(oper_summary));
endmodule

bind status_report status_report_checker status_report_checker_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .oper_cond_in(oper_cond_in),
    .ques_cond_in(ques_cond_in),
    .oper_summary(oper_summary),
    .ques_summary(ques_summary)
);
`default_nettype wire

// ==== bench/remote_ctrl.sv ====
// Remote controller model: issues register commands as an AXI4-Lite master.
// Assumes a slave on the same aclk; the bench calls wr and rd one at a time.
`timescale 1ns/10ps
`default_nettype none
module remote_ctrl (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Cycles before a response is taken; nonzero models a slow controller.
    int lag = 0;
    logic hung = 1'b0;

    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Released addresses and write data are inverted so that a slave sampling late sees a wrong value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (lag == 0);
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bready && bvalid)
                break;
            if (n >= lag)
                bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
        hung = hung | (n >= 100);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rready && rvalid)
                break;
            if (n >= lag)
                rready <= 1'b1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        hung = hung | (n >= 100);
    endtask
endmodule
`default_nettype wire

// ==== bench/status_report_tb_top.sv ====
// Self-checking bench for the status block, driven through the remote controller.
// Assumes the register map header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "status_map.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module status_report_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [14:0] oper_cond = '0;
    logic [14:0] ques_cond = '0;
    logic [15:0] err_code = '0;
    logic err_push = 1'b0;
    logic inst_reset = 1'b0;
    logic oper_summary, ques_summary, irq;
    int n_errors = 0;
    int checks_done = 0;

    always #2.5 aclk = ~aclk;

    status_report status_report_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .oper_cond_in(oper_cond), .ques_cond_in(ques_cond),
        .err_push(err_push), .err_code(err_code), .inst_reset(inst_reset),
        .oper_summary(oper_summary), .ques_summary(ques_summary), .irq(irq)
    );

    remote_ctrl remote_ctrl_inst (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    task automatic conclude;
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        remote_ctrl_inst.rd(a, d, r);
        `CHK(d, e)
        `CHK(r, er)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        remote_ctrl_inst.wr(a, d, 4'hf, r);
        `CHK(r, er)
    endtask

    // Two pulses are kept an idle cycle apart so that err_push is never driven twice at once.
    task automatic push(input logic [15:0] c);
        err_code <= c;
        err_push <= 1'b1;
        @(posedge aclk);
        err_push <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic defaults;
        for (int g = 0; g < 2; g++) begin
            rchk(`A_OPER_ENABLE + 8'(g * 20), 32'h0, `RESP_OKAY);
            rchk(`A_OPER_PTRANS + 8'(g * 20), 32'h7fff, `RESP_OKAY);
            rchk(`A_OPER_NTRANS + 8'(g * 20), 32'h0, `RESP_OKAY);
        end
    endtask

    always @(posedge aclk)
        if (remote_ctrl_inst.hung) begin
            n_errors++;
            conclude();
        end

    initial begin
        tick(5);
        aresetn <= 1'b1;
        defaults();
        rchk(`A_ERR_NEXT, 32'h0, `RESP_OKAY);
        oper_cond <= 15'h0005;
        tick(4);
        rchk(`A_OPER_COND, 32'h5, `RESP_OKAY);
        rchk(`A_OPER_COND, 32'h5, `RESP_OKAY);
        rchk(`A_OPER_EVENT, 32'h5, `RESP_OKAY);
        rchk(`A_OPER_EVENT, 32'h0, `RESP_OKAY);
        oper_cond <= 15'h0007;
        tick(2);
        oper_cond <= 15'h000f;
        tick(4);
        rchk(`A_OPER_EVENT, 32'ha, `RESP_OKAY);
        oper_cond <= 15'h0000;
        tick(4);
        rchk(`A_OPER_EVENT, 32'h0, `RESP_OKAY);
        wr(`A_OPER_NTRANS, 32'h1, `RESP_OKAY);
        oper_cond <= 15'h0003;
        tick(4);
        rchk(`A_OPER_EVENT, 32'h3, `RESP_OKAY);
        oper_cond <= 15'h0000;
        tick(4);
        rchk(`A_OPER_EVENT, 32'h1, `RESP_OKAY);
        wr(`A_OPER_ENABLE, 32'hffff_fff4, `RESP_OKAY);
        rchk(`A_OPER_ENABLE, 32'h7ff4, `RESP_OKAY);
        oper_cond <= 15'h000b;
        tick(6);
        `CHK(oper_summary, 1'b0)
        oper_cond <= 15'h000f;
        tick(6);
        `CHK(oper_summary, 1'b1)
        `CHK(ques_summary, 1'b0)
        inst_reset <= 1'b1;
        tick(1);
        inst_reset <= 1'b0;
        tick(6);
        `CHK(oper_summary, 1'b1)
        rchk(`A_OPER_ENABLE, 32'h7ff4, `RESP_OKAY);
        rchk(`A_OPER_EVENT, 32'hf, `RESP_OKAY);
        tick(6);
        `CHK(oper_summary, 1'b0)
        ques_cond <= 15'h0100;
        tick(4);
        rchk(`A_QUES_EVENT, 32'h100, `RESP_OKAY);
        rchk(`A_OPER_EVENT, 32'h0, `RESP_OKAY);
        wr(`A_OPER_PTRANS, 32'h0, `RESP_OKAY);
        wr(`A_QUES_NTRANS, 32'h55, `RESP_OKAY);
        wr(`A_QUES_ENABLE, 32'h1, `RESP_OKAY);
        ques_cond <= 15'h0101;
        tick(6);
        `CHK(ques_summary, 1'b1)
        wr(`A_PRESET, 32'h1, `RESP_OKAY);
        defaults();
        `CHK(ques_summary, 1'b0)
        remote_ctrl_inst.wr(`A_OPER_ENABLE, 32'h3, 4'h4, resp);
        `CHK(resp, `RESP_OKAY)
        rchk(`A_OPER_ENABLE, 32'h0, `RESP_OKAY);
        remote_ctrl_inst.lag = 3;
        wr(`A_IRQ_STATUS, 32'h7, `RESP_OKAY);
        wr(`A_IRQ_MASK, 32'h4, `RESP_OKAY);
        push(16'h0005);
        push(16'hfff0);
        tick(4);
        `CHK(irq, 1'b1)
        rchk(`A_ERR_COUNT, 32'h2, `RESP_OKAY);
        rchk(`A_ERR_NEXT, 32'h5, `RESP_OKAY);
        rchk(`A_ERR_NEXT, 32'hffff_fff0, `RESP_OKAY);
        rchk(`A_ERR_NEXT, 32'h0, `RESP_OKAY);
        wr(`A_IRQ_STATUS, 32'h4, `RESP_OKAY);
        tick(4);
        `CHK(irq, 1'b0)
        wr(`A_IRQ_MASK, 32'h0, `RESP_OKAY);
        push(16'h0001);
        tick(4);
        `CHK(irq, 1'b0)
        rchk(`A_IRQ_STATUS, 32'h4, `RESP_OKAY);
        for (int i = 0; i < 8; i++)
            push(16'(i + 2));
        rchk(`A_ERR_COUNT, 32'h18, `RESP_OKAY);
        rchk(`A_ERR_NEXT, 32'h1, `RESP_OKAY);
        rchk(8'h3c, 32'h0, `RESP_SLVERR);
        wr(8'h3c, 32'h1, `RESP_SLVERR);
        wr(`A_OPER_COND, 32'h1, `RESP_SLVERR);
        rchk(`A_OPER_COND, 32'hf, `RESP_OKAY);
        conclude();
    end
endmodule
`default_nettype wire
